// file: logic/mds_regs.svh
// Register map, field positions, reset values and constants of the sync control block
// Functional notes
// - In dual sync mode the sync strobe aligns divider and FIFO read pointer.
// - Read pointer restarts at a fixed offset, absorbing per-device data delay.
// - The external sync strobe is captured on the conversion clock.
// - With PLL enabled an internal strobe replaces the external one.
// - Feedback divider sync enable lets the realign input reset the feedback divider.
// - Realign rising edge, sampled on the reference clock, resets the feedback divider.
// - No timing tie between realign and frame or between the two clocks.
// - Single sync mode resamples the write-pointer reset into the read domain.
// - Resampling may shift latency by whole cycles; this is tolerated.
// - With PLL in single sync mode the read pointer ignores the strobe.
// - Internal strobe comes from the feedback divider output, at its rate.
`ifndef MDS_REGS_SVH
`define MDS_REGS_SVH

`define MDS_ADDR_W          8
`define MDS_DATA_W          32
`define MDS_OFF_GEN_CTRL    8'h00
`define MDS_OFF_PLL_CTRL    8'h04
`define MDS_OFF_SYNC_SRC    8'h08
`define MDS_OFF_ALARM_STAT  8'h0C
`define MDS_OFF_IRQ_MASK    8'h10
`define MDS_OFF_STATE       8'h14

// General control fields
`define MDS_GEN_SYNC_ENA    0
`define MDS_GEN_DUAL_MODE   1
// PLL control fields
`define MDS_PLL_ENA         0
`define MDS_PLL_NDIVSYNC    1
`define MDS_PLL_NDIV_LSB    8
`define MDS_PLL_NDIV_MSB    15
// Sync source field
`define MDS_SRC_SEL         0
// Status and mask fields
`define MDS_ST_SYNC         0
`define MDS_ST_REALIGN      1
`define MDS_ST_ALARM        2
`define MDS_ST_W            3
// State readback fields
`define MDS_RB_PTR_LSB      0
`define MDS_RB_DIV_LSB      4
`define MDS_RB_NDIV_LSB     8

`define MDS_PINS_ZERO       4'h0
`define MDS_PTR_W           3
`define MDS_CLKDIV_W        4
`define MDS_NDIV_W          8
`define MDS_RD_PTR_OFFSET   3'h4
`define MDS_NDIV_RST        8'h04
`define MDS_PTR_ZERO        3'h0
`define MDS_DIV_ZERO        4'h0
`define MDS_NDIV_ZERO       8'h00
`define MDS_NDIV_ONE        8'h01
`define MDS_ST_ZERO         3'h0
`define MDS_WORD_ZERO       32'h00000000

`endif

// file: logic/mds_pkg.sv
// Types of the sync control block
package mds_pkg;
    typedef enum logic {
        MDS_SRC_WR_RESET,
        MDS_SRC_STROBE
    } mds_src_t;
endpackage

// file: logic/mds_top.sv
// Multi-device sync control with Wishbone register access
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "mds_regs.svh"
module mds_top (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`MDS_ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [`MDS_DATA_W-1:0]   wb_dat_i,
    output logic      [`MDS_DATA_W-1:0]   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     sync_strobe_i,
    input  wire logic                     realign_i,
    input  wire logic                     wr_ptr_reset_i,
    input  wire logic                     fifo_alarm_i,
    output logic      [`MDS_PTR_W-1:0]    fifo_rd_ptr_o,
    output logic                          rd_ptr_reset_o,
    output logic      [`MDS_CLKDIV_W-1:0] clkdiv_count_o,
    output logic                          fb_div_strobe_o,
    output logic                          irq_o
);

    function automatic logic rise(input logic now_v, input logic old_v);
        rise = now_v & ~old_v;
    endfunction

    // Input synchronisers
    logic [3:0] meta;
    logic [3:0] stab;
    logic [3:0] stab_d;
    logic [3:0] next_meta;
    logic [3:0] next_stab;
    logic [3:0] next_stab_d;

    // Control registers
    logic                     sync_ena;
    logic                     dual_mode;
    logic                     pll_ena;
    logic                     ndivsync_ena;
    logic [`MDS_NDIV_W-1:0]   ndiv;
    mds_pkg::mds_src_t        src_sel;
    logic [`MDS_ST_W-1:0]     status;
    logic [`MDS_ST_W-1:0]     mask;
    logic                     next_sync_ena;
    logic                     next_dual_mode;
    logic                     next_pll_ena;
    logic                     next_ndivsync_ena;
    logic [`MDS_NDIV_W-1:0]   next_ndiv;
    mds_pkg::mds_src_t        next_src_sel;
    logic [`MDS_ST_W-1:0]     next_status;
    logic [`MDS_ST_W-1:0]     next_mask;
    logic [`MDS_DATA_W-1:0]   next_dat;
    logic                     next_ack;
    logic                     next_irq;

    // Datapath state
    logic [`MDS_NDIV_W-1:0]   ndiv_cnt;
    logic [`MDS_CLKDIV_W-1:0] clkdiv_cnt;
    logic [`MDS_PTR_W-1:0]    rd_ptr;
    logic                     fb_strobe;
    logic                     ptr_rst;
    logic [`MDS_NDIV_W-1:0]   next_ndiv_cnt;
    logic [`MDS_CLKDIV_W-1:0] next_clkdiv_cnt;
    logic [`MDS_PTR_W-1:0]    next_rd_ptr;
    logic                     next_fb_strobe;
    logic                     next_ptr_rst;

    // Decoded events
    logic                     strobe_edge;
    logic                     realign_edge;
    logic                     wr_rst_edge;
    logic                     alarm_edge;
    logic                     realign_hit;
    logic                     sync_event;
    logic                     sync_hit;
    logic                     wr_access;
    logic [`MDS_ST_W-1:0]     st_set;
    logic [`MDS_ST_W-1:0]     st_clr;
    logic [`MDS_NDIV_W-1:0]   ndiv_last;

    // Two flops before any logic reads a pin
    always_comb begin
        next_meta   = {fifo_alarm_i, wr_ptr_reset_i, realign_i, sync_strobe_i};
        next_stab   = meta;
        next_stab_d = stab;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= `MDS_PINS_ZERO;
            stab   <= `MDS_PINS_ZERO;
            stab_d <= `MDS_PINS_ZERO;
        end else begin
            meta   <= next_meta;
            stab   <= next_stab;
            stab_d <= next_stab_d;
        end
    end

    // Event decode
    always_comb begin
        strobe_edge  = rise(stab[0], stab_d[0]);
        realign_edge = rise(stab[1], stab_d[1]);
        wr_rst_edge  = rise(stab[2], stab_d[2]);
        alarm_edge   = rise(stab[3], stab_d[3]);
        // Realign acts only with PLL and its enable; no tie to frame or data clock
        realign_hit  = realign_edge & pll_ena & ndivsync_ena;
        ndiv_last    = (ndiv == `MDS_NDIV_ZERO) ? `MDS_NDIV_ZERO : ndiv - `MDS_NDIV_ONE;
        // Source choice per mode
        if (dual_mode && (src_sel == mds_pkg::MDS_SRC_STROBE)) begin
            // PLL mode uses internal strobe, bypass uses pin strobe
            sync_event = pll_ena ? fb_strobe : strobe_edge;
        end else begin
            // Single source: strobe never moves the read pointer
            sync_event = wr_rst_edge;
        end
        sync_hit = sync_event & sync_ena;
    end

    // Feedback divider
    always_comb begin
        next_fb_strobe  = 1'b0;
        next_ndiv_cnt   = ndiv_cnt + `MDS_NDIV_ONE;
        if (realign_hit) begin
            next_ndiv_cnt = `MDS_NDIV_ZERO;
        end else if (ndiv_cnt >= ndiv_last) begin
            next_ndiv_cnt  = `MDS_NDIV_ZERO;
            next_fb_strobe = pll_ena;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ndiv_cnt  <= `MDS_NDIV_ZERO;
            fb_strobe <= 1'b0;
        end else begin
            ndiv_cnt  <= next_ndiv_cnt;
            fb_strobe <= next_fb_strobe;
        end
    end

    // Clock divider and read pointer
    always_comb begin
        next_clkdiv_cnt = clkdiv_cnt + `MDS_CLKDIV_W'(1);
        next_rd_ptr     = rd_ptr + `MDS_PTR_W'(1);
        next_ptr_rst    = sync_hit;
        if (sync_hit) begin
            next_clkdiv_cnt = `MDS_DIV_ZERO;
            next_rd_ptr     = `MDS_RD_PTR_OFFSET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clkdiv_cnt <= `MDS_DIV_ZERO;
            rd_ptr     <= `MDS_PTR_ZERO;
            ptr_rst    <= 1'b0;
        end else begin
            clkdiv_cnt <= next_clkdiv_cnt;
            rd_ptr     <= next_rd_ptr;
            ptr_rst    <= next_ptr_rst;
        end
    end

    // Register writes, taken at the acknowledged edge
    always_comb begin
        wr_access         = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
        next_sync_ena     = sync_ena;
        next_dual_mode    = dual_mode;
        next_pll_ena      = pll_ena;
        next_ndivsync_ena = ndivsync_ena;
        next_ndiv         = ndiv;
        next_src_sel      = src_sel;
        next_mask         = mask;
        st_clr            = `MDS_ST_ZERO;
        if (wr_access) begin
            unique case (wb_adr_i)
                `MDS_OFF_GEN_CTRL: begin
                    next_sync_ena  = wb_dat_i[`MDS_GEN_SYNC_ENA];
                    next_dual_mode = wb_dat_i[`MDS_GEN_DUAL_MODE];
                end
                `MDS_OFF_PLL_CTRL: begin
                    next_pll_ena      = wb_dat_i[`MDS_PLL_ENA];
                    next_ndivsync_ena = wb_dat_i[`MDS_PLL_NDIVSYNC];
                    if (wb_sel_i[1]) begin
                        next_ndiv = wb_dat_i[`MDS_PLL_NDIV_MSB:`MDS_PLL_NDIV_LSB];
                    end
                end
                `MDS_OFF_SYNC_SRC: begin
                    next_src_sel = wb_dat_i[`MDS_SRC_SEL] ? mds_pkg::MDS_SRC_STROBE
                                                          : mds_pkg::MDS_SRC_WR_RESET;
                end
                `MDS_OFF_ALARM_STAT: begin
                    st_clr = wb_dat_i[`MDS_ST_W-1:0];
                end
                `MDS_OFF_IRQ_MASK: begin
                    next_mask = wb_dat_i[`MDS_ST_W-1:0];
                end
                default: begin
                    next_mask = mask;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_ena     <= 1'b0;
            dual_mode    <= 1'b0;
            pll_ena      <= 1'b0;
            ndivsync_ena <= 1'b0;
            ndiv         <= `MDS_NDIV_RST;
            src_sel      <= mds_pkg::MDS_SRC_WR_RESET;
            mask         <= `MDS_ST_ZERO;
        end else begin
            sync_ena     <= next_sync_ena;
            dual_mode    <= next_dual_mode;
            pll_ena      <= next_pll_ena;
            ndivsync_ena <= next_ndivsync_ena;
            ndiv         <= next_ndiv;
            src_sel      <= next_src_sel;
            mask         <= next_mask;
        end
    end

    // Status and interrupt
    always_comb begin
        st_set                  = `MDS_ST_ZERO;
        st_set[`MDS_ST_SYNC]    = sync_hit;
        st_set[`MDS_ST_REALIGN] = realign_hit;
        st_set[`MDS_ST_ALARM]   = alarm_edge;
        // Set wins over a same-cycle clear
        next_status = (status & ~st_clr) | st_set;
        next_irq    = |(next_status & next_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= `MDS_ST_ZERO;
            irq_o  <= 1'b0;
        end else begin
            status <= next_status;
            irq_o  <= next_irq;
        end
    end

    // Read data and acknowledge
    always_comb begin
        next_ack    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat    = `MDS_WORD_ZERO;
        unique case (wb_adr_i)
            `MDS_OFF_GEN_CTRL: begin
                next_dat[`MDS_GEN_SYNC_ENA]  = sync_ena;
                next_dat[`MDS_GEN_DUAL_MODE] = dual_mode;
            end
            `MDS_OFF_PLL_CTRL: begin
                next_dat[`MDS_PLL_ENA]                         = pll_ena;
                next_dat[`MDS_PLL_NDIVSYNC]                    = ndivsync_ena;
                next_dat[`MDS_PLL_NDIV_MSB:`MDS_PLL_NDIV_LSB] = ndiv;
            end
            `MDS_OFF_SYNC_SRC: begin
                next_dat[`MDS_SRC_SEL] = (src_sel == mds_pkg::MDS_SRC_STROBE);
            end
            `MDS_OFF_ALARM_STAT: begin
                next_dat[`MDS_ST_W-1:0] = status;
            end
            `MDS_OFF_IRQ_MASK: begin
                next_dat[`MDS_ST_W-1:0] = mask;
            end
            `MDS_OFF_STATE: begin
                next_dat[`MDS_RB_PTR_LSB +: `MDS_PTR_W]     = rd_ptr;
                next_dat[`MDS_RB_DIV_LSB +: `MDS_CLKDIV_W]  = clkdiv_cnt;
                next_dat[`MDS_RB_NDIV_LSB +: `MDS_NDIV_W]   = ndiv_cnt;
            end
            default: begin
                next_dat = `MDS_WORD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `MDS_WORD_ZERO;
            wb_ack_o <= 1'b0;
        end else begin
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    // Outputs straight from flops
    always_comb begin
        fifo_rd_ptr_o   = rd_ptr;
        rd_ptr_reset_o  = ptr_rst;
        clkdiv_count_o  = clkdiv_cnt;
        fb_div_strobe_o = fb_strobe;
    end

endmodule

// file: sim/mds_props.sv
// Checker of the sync control block ports
`timescale 1ns/1ps
module mds_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sync_strobe_i,
    input wire logic        realign_i,
    input wire logic        wr_ptr_reset_i,
    input wire logic        fifo_alarm_i,
    input wire logic [2:0]  fifo_rd_ptr_o,
    input wire logic        rd_ptr_reset_o,
    input wire logic [3:0]  clkdiv_count_o,
    input wire logic        fb_div_strobe_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h17)
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    sync_load_a: assert property (rd_ptr_reset_o |->
        fifo_rd_ptr_o == 3'h4 && clkdiv_count_o == 4'h0) else $error("sync load wrong");
    sync_resume_a: assert property (rd_ptr_reset_o ##1 !rd_ptr_reset_o |->
        fifo_rd_ptr_o == 3'h5 && clkdiv_count_o == 4'h1) else $error("resume wrong");
    count_run_a: assert property (!rd_ptr_reset_o && !$past(rst_i) && !$past(rst_i, 2)
        |-> fifo_rd_ptr_o == $past(fifo_rd_ptr_o) + 3'h1
        && clkdiv_count_o == $past(clkdiv_count_o) + 4'h1) else $error("count stalled");
    sync_cause_a: assert property (rd_ptr_reset_o |->
        ($past(sync_strobe_i, 3) && !$past(sync_strobe_i, 4))
        || ($past(wr_ptr_reset_i, 3) && !$past(wr_ptr_reset_i, 4))
        || $past(fb_div_strobe_o)) else $error("sync without cause");
    irq_clear_a: assert property ($fell(irq_o) |-> $past(wb_stb_i && wb_we_i)
        || $past(wb_stb_i && wb_we_i, 2)) else $error("irq fell without write");
    cover property (rd_ptr_reset_o);
    cover property (fb_div_strobe_o ##1 rd_ptr_reset_o);
    cover property ($rose(irq_o));
endmodule
bind mds_top mds_props u_props (.*);

// file: sim/mds_partner.sv
// Clock distribution and data source model driving the sync pins
`timescale 1ns/1ps
module mds_partner (
    input  wire logic clk_i,
    output logic      sync_strobe_o,
    output logic      realign_o,
    output logic      wr_ptr_reset_o,
    output logic      fifo_alarm_o
);
    logic [3:0] pins = 4'h0;
    assign sync_strobe_o = pins[0];
    assign realign_o = pins[1];
    assign wr_ptr_reset_o = pins[2];
    assign fifo_alarm_o = pins[3];
    // Single pulse launched on the conversion clock edge
    task automatic pulse(input int pin, input int width);
        @(posedge clk_i);
        pins[pin] <= 1'b1;
        repeat (width) @(posedge clk_i);
        pins[pin] <= 1'b0;
        repeat (width) @(posedge clk_i);
    endtask
endmodule

// file: sim/mds_top_tb.sv
// Testbench of the sync control block
`timescale 1ns/1ps
module mds_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [2:0]  rd_ptr;
    logic [3:0]  clkdiv;
    logic        ack, strobe, realign, wr_rst, alarm, rd_rst, fb_stb, irq;
    int          bad_count = 0;
    int          compares = 0;
    always #4 clk_i = ~clk_i;
    mds_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sync_strobe_i(strobe), .realign_i(realign), .wr_ptr_reset_i(wr_rst),
        .fifo_alarm_i(alarm), .fifo_rd_ptr_o(rd_ptr), .rd_ptr_reset_o(rd_rst),
        .clkdiv_count_o(clkdiv), .fb_div_strobe_o(fb_stb), .irq_o(irq));
    mds_partner PAR (.clk_i(clk_i), .sync_strobe_o(strobe), .realign_o(realign),
        .wr_ptr_reset_o(wr_rst), .fifo_alarm_o(alarm));
    task automatic give_verdict;
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(name, e, q);
    endtask
    // Counts sync pulses and internal strobes for n cycles, alongside a pin pulse unless pin is negative
    task automatic tally(input int pin, input int n, output int rp, output int fb);
        rp = 0;
        fb = 0;
        fork
            if (pin >= 0) PAR.pulse(pin, 2);
            repeat (n) begin
                @(posedge clk_i);
                rp += int'(rd_rst === 1'b1);
                fb += int'(fb_stb === 1'b1);
            end
        join
    endtask
    task automatic reset_values;
        logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        logic [31:0] e [6] = '{32'h0, 32'h400, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset value", a[i], e[i]);
        end
    endtask
    task automatic sync_dual;
        int rp, fb;
        wr(8'h10, 32'h7);
        wr(8'h08, 32'h1);
        for (int en = 0; en < 2; en++) begin
            wr(8'h00, 32'h2 | en);
            tally(0, 12, rp, fb);
            check("strobe sync", en, rp);
        end
        check("irq on sync", 32'h1, irq);
        rd_chk("status sync", 8'h0C, 32'h1);
        wr(8'h0C, 32'h1);
        rd_chk("status cleared", 8'h0C, 32'h0);
        wr(8'h00, 32'h2);
        tally(0, 12, rp, fb);
        check("sync after disable", 32'h0, rp);
    endtask
    task automatic single_pll;
        int rp, fb;
        wr(8'h04, 32'h401);
        wr(8'h00, 32'h1);
        tally(2, 12, rp, fb);
        check("wr reset sync", 32'h1, rp);
        tally(0, 12, rp, fb);
        check("strobe ignored", 32'h0, rp);
    endtask
    task automatic pll_mode;
        int rp, fb;
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h303);
        tally(-1, 30, rp, fb);
        check("internal strobes", 32'hA, fb);
        check("internal syncs", 32'hA, rp);
        wr(8'h0C, 32'h7);
        tally(1, 8, rp, fb);
        rd_chk("realign applied", 8'h0C, 32'h3);
        wr(8'h04, 32'h301);
        wr(8'h0C, 32'h7);
        tally(1, 8, rp, fb);
        rd_chk("realign ignored", 8'h0C, 32'h1);
        wr(8'h00, 32'h2);
    endtask
    task automatic alarm_irq;
        wr(8'h0C, 32'h7);
        wr(8'h10, 32'h4);
        PAR.pulse(3, 2);
        check("irq on alarm", 32'h1, irq);
        rd_chk("status alarm", 8'h0C, 32'h4);
        wr(8'h10, 32'h0);
        repeat (2) @(posedge clk_i);
        check("irq masked", 32'h0, irq);
        wr(8'h0C, 32'h4);
        rd_chk("alarm cleared", 8'h0C, 32'h0);
    endtask
    // Two readbacks three cycles apart, no sync enabled, divider period 3
    task automatic state_step;
        logic [31:0] q1, q2;
        bus(1'b0, 8'h14, 32'h0, q1);
        bus(1'b0, 8'h14, 32'h0, q2);
        check("state step", {16'h0, q1[15:8], q1[7:4] + 4'h3, 1'b0, q1[2:0] + 3'h3},
              q2);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        reset_values();
        sync_dual();
        single_pll();
        pll_mode();
        alarm_irq();
        state_step();
        give_verdict();
    end
    initial begin
        #60000;
        bad_count++;
        give_verdict();
    end
endmodule
